// *** aifs_top.sv ***
`timescale 1ns/1ps
// Two programmable contact inputs mapped onto motor commands
module aifs_top
  import aifs_pkg::*;
#(
  // Cycles in one second of ramp timing; shorten for simulation
  parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
  // Clock, reset, clock enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // Contact pins, high while closed to common return
  input wire logic AUX_INPUT_THREE,
  input wire logic AUX_INPUT_FOUR,
  // Function codes and system settings
  input wire logic [FN_W-1:0] SEL_THREE,
  input wire logic [FN_W-1:0] SEL_FOUR,
  input wire logic [CFG_W-1:0] SYS_CFG,
  input wire logic [DELAY_W-1:0] RESTART_DELAY_S,
  // Run request from keypad and other sources
  input wire logic RUN_CMD,
  // Keypad pulses and clock edit mode
  input wire logic KEY_ENTER,
  input wire logic KEY_UP,
  input wire logic KEY_DOWN,
  input wire logic RTC_EDIT,
  // Motor commands
  output logic MOTOR_RUN,
  output logic MOTOR_REV,
  output logic MAX_FREQ,
  output logic PROT_BYPASS,
  output logic RAMP_ACTIVE,
  // Display status
  output logic FAULT_THREE,
  output logic FAULT_FOUR,
  output logic SPECIAL_FN,
  // Speed table selection
  output logic SPEED_SEL,
  output logic [1:0] SPEED_IDX,
  // Clock entry
  output logic [RTC_CUR_W-1:0] RTC_CURSOR,
  output logic [RTC_BITS-1:0] RTC_VALUE,
  output logic RTC_LOAD
);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SEC_CYCLES_P - 1);

  // Synchroniser stages; stage one is read by stage two only
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  // Contact closed, bit 0 is input three
  logic [1:0] closed;
  // Raw and applied function codes
  logic [1:0][FN_W-1:0] sel_raw;
  logic [1:0][FN_W-1:0] eff;
  // Preset has taken the inputs over
  logic special;
  // Per-input decode
  logic [1:0] permit;
  logic [1:0] is_rev;
  logic [1:0] is_speed;
  logic [1:0] fire_fwd_i;
  logic [1:0] fire_rev_i;
  logic [1:0] fault_set;
  // Latched stop faults
  logic [1:0] fault_q;
  logic [1:0] fault_d;
  logic fault_clr;
  // Override decode
  logic fire_fwd;
  logic fire_rev;
  logic override;
  // Reversal sequencer
  aifs_state_type st_q;
  aifs_state_type st_d;
  logic dir_q;
  logic dir_d;
  logic tgt_q;
  logic tgt_d;
  logic rev_want;
  logic ramp_load;
  logic [LEFT_W-1:0] ramp_total;
  logic [LEFT_W-1:0] left_q;
  logic [LEFT_W-1:0] left_d;
  logic [TICK_W-1:0] tick_q;
  logic sec_tick;
  // Output next values
  logic run_d;
  logic rev_d;

  // Two flops on the contact pins before any decode
  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
    end else if (CE) begin
      pin_s1_q <= {AUX_INPUT_FOUR, AUX_INPUT_THREE};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign closed = pin_s2_q;
  assign sel_raw = {SEL_FOUR, SEL_THREE};

  // Presets 2, 3, 5 and 6 replace both selections
  assign special = (SYS_CFG == CFG_SP_A) || (SYS_CFG == CFG_SP_B) ||
                   (SYS_CFG == CFG_SP_C) || (SYS_CFG == CFG_SP_D);

  // Enter is shared with clock entry, so it clears only outside edit
  assign fault_clr = KEY_ENTER && !RTC_EDIT;

  // Same decode for each input
  for (genvar i = 0; i < 2; i++) begin : g_in
    logic supported;
    assign eff[i] = special ? FN_SPECIAL : sel_raw[i];
    assign supported = eff[i] <= FN_SPECIAL;
    // Codes 0 and 1 follow the contact, unknown codes refuse to run
    assign permit[i] = (eff[i] == FN_RUN_CLOSED) ? closed[i] :
                       (eff[i] == FN_RUN_OPEN) ? !closed[i] :
                       supported;
    assign is_rev[i] = eff[i] == FN_REVERSE;
    assign is_speed[i] = eff[i] == FN_SPEED;
    assign fire_fwd_i[i] = (eff[i] == FN_FIRE_FWD) && closed[i];
    assign fire_rev_i[i] = (eff[i] == FN_FIRE_REV) && closed[i];
    assign fault_set[i] = ((eff[i] == FN_LATCH_OPEN) && !closed[i]) ||
                          ((eff[i] == FN_LATCH_CLOSED) && closed[i]);
    // A trip in the clearing cycle survives the clear
    assign fault_d[i] = fault_set[i] || (fault_q[i] && !fault_clr);
  end

  // Forward override wins if both kinds are active
  assign fire_fwd = |fire_fwd_i;
  assign fire_rev = |fire_rev_i;
  assign override = fire_fwd || fire_rev;

  // Closed on any code 4 input asks for reverse
  assign rev_want = |(is_rev & closed);
  assign ramp_total = RAMP_S + {2'h0, RESTART_DELAY_S};
  assign ramp_load = ((st_q == ST_RUN) && (rev_want != dir_q)) ||
                     ((st_q == ST_RAMP) && (rev_want != tgt_q));
  assign sec_tick = tick_q == TICK_LAST;

  // Reversal sequencer: stop, wait the full ramp, swap direction
  always_comb begin
    st_d = st_q;
    tgt_d = tgt_q;
    left_d = left_q;
    dir_d = dir_q;
    unique case (st_q)
      ST_RUN: begin
        // Any change of wanted direction starts a ramp
        if (ramp_load) begin
          st_d = ST_RAMP;
          tgt_d = rev_want;
          left_d = ramp_total;
        end
      end
      ST_RAMP: begin
        if (ramp_load) begin
          // Another change restarts the full wait
          tgt_d = rev_want;
          left_d = ramp_total;
        end else if (sec_tick) begin
          if (left_q == LEFT_ONE) begin
            st_d = ST_RUN;
            dir_d = tgt_q;
          end else begin
            left_d = left_q - LEFT_ONE;
          end
        end
      end
      default: begin
        // Illegal code: recover to running
        st_d = ST_RUN;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q <= ST_RUN;
      dir_q <= 1'b0;
      tgt_q <= 1'b0;
      left_q <= '0;
    end else if (CE) begin
      st_q <= st_d;
      dir_q <= dir_d;
      tgt_q <= tgt_d;
      left_q <= left_d;
    end
  end

  // Second prescaler, only running while ramping
  always_ff @(posedge CLK) begin
    if (RST) begin
      tick_q <= '0;
    end else if (CE) begin
      if (ramp_load || (st_q != ST_RAMP) || sec_tick) begin
        tick_q <= '0;
      end else begin
        tick_q <= tick_q + 25'h0000001;
      end
    end
  end

  // Override ignores run command, faults and ramps
  // A trip stops the motor in the same cycle that latches the fault
  assign run_d = override || (RUN_CMD && (st_q == ST_RUN) && !ramp_load &&
                 (&permit) && !(|(fault_q | fault_set)));
  assign rev_d = override ? (fire_rev && !fire_fwd) : dir_q;

  // Registered outputs
  always_ff @(posedge CLK) begin
    if (RST) begin
      fault_q <= 2'h0;
      MOTOR_RUN <= 1'b0;
      MOTOR_REV <= 1'b0;
      MAX_FREQ <= 1'b0;
      PROT_BYPASS <= 1'b0;
      SPECIAL_FN <= 1'b0;
      SPEED_SEL <= 1'b0;
      SPEED_IDX <= 2'h0;
    end else if (CE) begin
      fault_q <= fault_d;
      MOTOR_RUN <= run_d;
      MOTOR_REV <= rev_d;
      MAX_FREQ <= override;
      PROT_BYPASS <= override;
      SPECIAL_FN <= special;
      SPEED_SEL <= |is_speed;
      SPEED_IDX <= closed;
    end
  end

  assign FAULT_THREE = fault_q[0];
  assign FAULT_FOUR = fault_q[1];
  assign RAMP_ACTIVE = st_q == ST_RAMP;

  // Clock entry editor
  aifs_rtc_entry u_rtc (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .edit(RTC_EDIT),
    .key_enter(KEY_ENTER),
    .key_up(KEY_UP),
    .key_down(KEY_DOWN),
    .cursor(RTC_CURSOR),
    .value(RTC_VALUE),
    .load(RTC_LOAD)
  );

  sequence s_trip_open;
    CE && (eff[0] == FN_LATCH_OPEN) && !closed[0];
  endsequence
  sequence s_trip_closed;
    CE && (eff[1] == FN_LATCH_CLOSED) && closed[1];
  endsequence
  sequence s_stopped;
    FAULT_THREE ##0 !MOTOR_RUN;
  endsequence

  property p_run_closed;
    @(posedge CLK) disable iff (RST)
    (CE && (eff[0] == FN_RUN_CLOSED) && !closed[0] && !override) |=> !MOTOR_RUN;
  endproperty
  a_run_closed: assert property (p_run_closed) else $error("code 0 ran while open");

  property p_run_open;
    @(posedge CLK) disable iff (RST)
    (CE && (eff[1] == FN_RUN_OPEN) && closed[1] && !override) |=> !MOTOR_RUN;
  endproperty
  a_run_open: assert property (p_run_open) else $error("code 1 ran while closed");

  property p_always;
    @(posedge CLK) disable iff (RST)
    (CE && (eff == {FN_ALWAYS, FN_ALWAYS}) && RUN_CMD && !ramp_load &&
     (st_q == ST_RUN) && !(|fault_q)) |=> MOTOR_RUN;
  endproperty
  a_always: assert property (p_always) else $error("code 2 did not run");

  property p_latch_open;
    @(posedge CLK) disable iff (RST)
    (s_trip_open ##0 !override) |=> s_stopped;
  endproperty
  a_latch_open: assert property (p_latch_open) else $error("open trip not latched");

  property p_latch_closed;
    @(posedge CLK) disable iff (RST)
    s_trip_closed |=> FAULT_FOUR;
  endproperty
  a_latch_closed: assert property (p_latch_closed) else $error("closed trip not latched");

  property p_fault_holds;
    @(posedge CLK) disable iff (RST)
    (FAULT_FOUR && !(CE && fault_clr)) |=> FAULT_FOUR;
  endproperty
  a_fault_holds: assert property (p_fault_holds) else $error("fault dropped without Enter");

  property p_ramp_stop;
    @(posedge CLK) disable iff (RST)
    (CE && (st_q == ST_RAMP) && !override) |=> !MOTOR_RUN;
  endproperty
  a_ramp_stop: assert property (p_ramp_stop) else $error("ran during reversal ramp");

  property p_ramp_wait;
    @(posedge CLK) disable iff (RST)
    ((st_q == ST_RAMP) && (left_q > LEFT_ONE)) |=> (st_q == ST_RAMP);
  endproperty
  a_ramp_wait: assert property (p_ramp_wait) else $error("ramp ended early");

  property p_direction;
    @(posedge CLK) disable iff (RST)
    (CE && !override) |=> (MOTOR_REV == $past(dir_q));
  endproperty
  a_direction: assert property (p_direction) else $error("wrong rotation");

  property p_speed;
    @(posedge CLK) disable iff (RST)
    (CE && (|is_speed)) |=> (SPEED_SEL && (SPEED_IDX == $past(closed)));
  endproperty
  a_speed: assert property (p_speed) else $error("speed select wrong");

  property p_fire_fwd;
    @(posedge CLK) disable iff (RST)
    (CE && fire_fwd) |=> (MOTOR_RUN && MAX_FREQ && PROT_BYPASS && !MOTOR_REV);
  endproperty
  a_fire_fwd: assert property (p_fire_fwd) else $error("forward override failed");

  property p_fire_rev;
    @(posedge CLK) disable iff (RST)
    (CE && fire_rev && !fire_fwd && !RUN_CMD) |=> (MOTOR_RUN && MAX_FREQ && MOTOR_REV);
  endproperty
  a_fire_rev: assert property (p_fire_rev) else $error("reverse override failed");

  property p_special;
    @(posedge CLK) disable iff (RST)
    (CE && special) |=> (SPECIAL_FN && !SPEED_SEL && !MAX_FREQ);
  endproperty
  a_special: assert property (p_special) else $error("preset did not force code 9");

  property p_unsupported;
    @(posedge CLK) disable iff (RST)
    (CE && (eff[0] > FN_SPECIAL) && !override) |=> !MOTOR_RUN;
  endproperty
  a_unsupported: assert property (p_unsupported) else $error("unknown code ran");
endmodule

// *** aifs_pkg.sv ***
package aifs_pkg;
  // Clock rate and one-second timebase
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned SEC_CYCLES = TICK_S * CLK_HZ;
  localparam int unsigned TICK_W = 25;
  // Ramp down time in seconds
  localparam int unsigned LEFT_W = 10;
  localparam logic [LEFT_W-1:0] RAMP_S = 10'h01E;
  localparam logic [LEFT_W-1:0] LEFT_ONE = 10'h001;
  localparam int unsigned DELAY_W = 8;
  // Function codes
  localparam int unsigned FN_W = 4;
  localparam logic [FN_W-1:0] FN_RUN_CLOSED = 4'h0;
  localparam logic [FN_W-1:0] FN_RUN_OPEN = 4'h1;
  localparam logic [FN_W-1:0] FN_ALWAYS = 4'h2;
  localparam logic [FN_W-1:0] FN_LATCH_OPEN = 4'h3;
  localparam logic [FN_W-1:0] FN_REVERSE = 4'h4;
  localparam logic [FN_W-1:0] FN_LATCH_CLOSED = 4'h5;
  localparam logic [FN_W-1:0] FN_SPEED = 4'h6;
  localparam logic [FN_W-1:0] FN_FIRE_FWD = 4'h7;
  localparam logic [FN_W-1:0] FN_FIRE_REV = 4'h8;
  localparam logic [FN_W-1:0] FN_SPECIAL = 4'h9;
  // Presets that take over the inputs
  localparam int unsigned CFG_W = 3;
  localparam logic [CFG_W-1:0] CFG_SP_A = 3'h2;
  localparam logic [CFG_W-1:0] CFG_SP_B = 3'h3;
  localparam logic [CFG_W-1:0] CFG_SP_C = 3'h5;
  localparam logic [CFG_W-1:0] CFG_SP_D = 3'h6;
  // Clock entry: MO DD YR HH MM SS, digit 0 first, LSB nibble first
  localparam int unsigned RTC_DIGITS = 12;
  localparam int unsigned RTC_CUR_W = 4;
  localparam int unsigned RTC_BITS = 48;
  localparam logic [RTC_CUR_W-1:0] RTC_LAST = 4'hB;
  localparam logic [RTC_BITS-1:0] RTC_MAX = 48'h959592999391;
  localparam logic [3:0] DIGIT_ZERO = 4'h0;
  localparam logic [3:0] DIGIT_ONE = 4'h1;
  // Reversal sequencer states
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_RAMP = 2'b10
  } aifs_state_type;
endpackage

// *** aifs_rtc_entry.sv ***
`timescale 1ns/1ps
// Keypad entry of the real-time clock digits
module aifs_rtc_entry
  import aifs_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Keypad
  input wire logic edit,
  input wire logic key_enter,
  input wire logic key_up,
  input wire logic key_down,
  // Entry state
  output logic [RTC_CUR_W-1:0] cursor,
  output logic [RTC_BITS-1:0] value,
  output logic load
);
  // Cursor position and wrap pulse
  logic [RTC_CUR_W-1:0] cur_q;
  logic load_q;
  // Digit store
  logic [3:0] dig_q [RTC_DIGITS];
  logic step_right;
  logic at_last;

  // Enter only moves the cursor while editing
  assign step_right = edit && key_enter;
  assign at_last = cur_q == RTC_LAST;
  assign cursor = cur_q;
  assign load = load_q;

  // Cursor walks right and wraps after the last seconds digit
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_q <= '0;
      load_q <= 1'b0;
    end else if (ce) begin
      load_q <= step_right && at_last;
      if (step_right) begin
        cur_q <= at_last ? '0 : cur_q + 4'h1;
      end
    end
  end

  // Each digit steps within its own limit; no month-length check
  for (genvar i = 0; i < RTC_DIGITS; i++) begin : g_dig
    localparam logic [3:0] DMAX = RTC_MAX[i*4 +: 4];
    logic here;
    logic [3:0] up_v;
    logic [3:0] dn_v;
    assign here = edit && (cur_q == RTC_CUR_W'(i));
    assign up_v = (dig_q[i] == DMAX) ? DIGIT_ZERO : dig_q[i] + DIGIT_ONE;
    assign dn_v = (dig_q[i] == DIGIT_ZERO) ? DMAX : dig_q[i] - DIGIT_ONE;
    assign value[i*4 +: 4] = dig_q[i];
    // Up wins when both keys arrive together
    always_ff @(posedge clk) begin
      if (rst) begin
        dig_q[i] <= DIGIT_ZERO;
      end else if (ce && here) begin
        if (key_up) begin
          dig_q[i] <= up_v;
        end else if (key_down) begin
          dig_q[i] <= dn_v;
        end
      end
    end
  end

  property p_cursor_step;
    @(posedge clk) disable iff (rst)
    (ce && step_right && !at_last) |=> (cur_q == $past(cur_q) + 4'h1);
  endproperty
  a_cursor_step: assert property (p_cursor_step) else $error("cursor did not step");

  property p_digit_hold;
    @(posedge clk) disable iff (rst)
    (ce && !edit) |=> (value == $past(value));
  endproperty
  a_digit_hold: assert property (p_digit_hold) else $error("digit changed outside edit");
endmodule

// *** aifs_contacts.sv ***
`timescale 1ns/1ps
// Dry switch contacts wired from each input to the common return
module aifs_contacts (
  // Wanted contact state, high = closed
  input wire logic closed_three,
  input wire logic closed_four,
  // Pins into the drive, high while the contact is closed
  output logic pin_three,
  output logic pin_four
);
  // No bounce is modelled; the drive's synchronisers only see clean levels here
  assign pin_three = closed_three;
  assign pin_four = closed_four;
endmodule

// *** aux_input_function_select_bench.sv ***
`timescale 1ns/1ps
// Self-checking bench for the two programmable contact inputs
module aux_input_function_select_bench;
  import aifs_pkg::*;
  // Short second keeps the reversal ramp to 128 cycles
  localparam int unsigned SEC_P = 4;
  localparam int unsigned HOLD_S = 2;
  localparam int RAMP_N = (30 + HOLD_S) * SEC_P;
  logic clk = 1'b0;
  logic rst, ce, run_cmd, edit, closed_three, closed_four, pin_three, pin_four, exp_b;
  logic [FN_W-1:0] sel_three, sel_four;
  logic [CFG_W-1:0] sys_cfg;
  logic [DELAY_W-1:0] hold;
  logic [2:0] keys;
  logic run, rev, maxf, byp, ramp, f3, f4, spec, ssel, load;
  logic [1:0] sidx;
  logic [RTC_CUR_W-1:0] cursor;
  logic [RTC_BITS-1:0] value;
  int error_cnt = 0;
  int checks = 0;
  int n;

  // 20 MHz clock
  always #25 clk = ~clk;

  // Contact partner
  aifs_contacts sw (.closed_three(closed_three), .closed_four(closed_four),
    .pin_three(pin_three), .pin_four(pin_four));

  // Design with a shortened second
  aifs_top #(.SEC_CYCLES_P(SEC_P)) dut (.CLK(clk), .RST(rst), .CE(ce),
    .AUX_INPUT_THREE(pin_three), .AUX_INPUT_FOUR(pin_four), .SEL_THREE(sel_three),
    .SEL_FOUR(sel_four), .SYS_CFG(sys_cfg), .RESTART_DELAY_S(hold), .RUN_CMD(run_cmd),
    .KEY_ENTER(keys[0]), .KEY_UP(keys[1]), .KEY_DOWN(keys[2]), .RTC_EDIT(edit),
    .MOTOR_RUN(run), .MOTOR_REV(rev), .MAX_FREQ(maxf), .PROT_BYPASS(byp),
    .RAMP_ACTIVE(ramp), .FAULT_THREE(f3), .FAULT_FOUR(f4), .SPECIAL_FN(spec),
    .SPEED_SEL(ssel), .SPEED_IDX(sidx), .RTC_CURSOR(cursor), .RTC_VALUE(value),
    .RTC_LOAD(load));

  // Let n edges pass and sample just after the last one
  task automatic settle(input int cyc);
    repeat (cyc) @(posedge clk);
    #1;
  endtask

  // One-cycle key pulse, bits are {down, up, enter}
  task automatic press(input logic [2:0] k);
    @(posedge clk);
    keys <= k;
    @(posedge clk);
    keys <= 3'b000;
  endtask

  // Single-bit result compare
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // Multi-bit result compare
  task automatic chk_val(input logic [47:0] got, input logic [47:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Trip a latched fault, restore the contact, then clear it with Enter
  task automatic latch_check(input logic four);
    @(posedge clk);
    sel_three <= FN_ALWAYS;
    sel_four <= FN_ALWAYS;
    closed_three <= 1'b1;
    closed_four <= 1'b0;
    settle(4);
    @(posedge clk);
    if (four) sel_four <= FN_LATCH_CLOSED;
    else sel_three <= FN_LATCH_OPEN;
    settle(4);
    chk_bit(run, 1'b1, "run before trip");
    @(posedge clk);
    if (four) closed_four <= 1'b1;
    else closed_three <= 1'b0;
    settle(4);
    chk_bit(four ? f4 : f3, 1'b1, "fault raised");
    chk_bit(run, 1'b0, "stop on trip");
    @(posedge clk);
    if (four) closed_four <= 1'b0;
    else closed_three <= 1'b1;
    settle(6);
    chk_bit(run, 1'b0, "stays stopped after restore");
    press(3'b001);
    settle(3);
    chk_bit(four ? f4 : f3, 1'b0, "fault cleared");
    chk_bit(run, 1'b1, "runs after clear");
  endtask

  // Count report and verdict, the only exit
  task automatic summarize();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    run_cmd = 1'b1;
    edit = 1'b0;
    keys = 3'b000;
    closed_three = 1'b0;
    closed_four = 1'b0;
    sel_three = FN_ALWAYS;
    sel_four = FN_ALWAYS;
    sys_cfg = 3'h0;
    hold = HOLD_S[DELAY_W-1:0];
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle(4);
    // Codes 0, 1 and 2 and an unsupported code, both contact states each
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        sel_three <= (c == 3) ? 4'hA : c[3:0];
        sel_four <= (c == 3) ? 4'hA : c[3:0];
        closed_three <= k[0];
        closed_four <= k[0];
        settle(4);
        exp_b = (c == 0) ? k[0] : (c == 1) ? !k[0] : (c == 2);
        chk_bit(run, exp_b, "run for code and contact");
      end
    end
    $display("test polarity done");
    latch_check(1'b0);
    latch_check(1'b1);
    $display("test latch done");
    // Reversal: close then open, each change ramps and flips direction
    @(posedge clk);
    sel_three <= FN_REVERSE;
    closed_three <= 1'b0;
    settle(RAMP_N + 20);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      closed_three <= (k == 0);
      n = 0;
      while (ramp !== 1'b1 && n < 20) begin
        settle(1);
        n++;
      end
      chk_bit(ramp, 1'b1, "ramp started");
      chk_bit(run, 1'b0, "stopped during ramp");
      n = 0;
      while (ramp === 1'b1 && n < 1000) begin
        settle(1);
        n++;
      end
      chk_bit(n >= RAMP_N - SEC_P && n <= RAMP_N + SEC_P, 1'b1, "ramp length");
      settle(2);
      chk_bit(rev, k == 0, "direction after ramp");
      chk_bit(run, 1'b1, "runs after ramp");
    end
    $display("test reversal done");
    // Overrides with the run request withdrawn
    @(posedge clk);
    run_cmd <= 1'b0;
    sel_three <= FN_FIRE_FWD;
    sel_four <= FN_FIRE_REV;
    closed_three <= 1'b0;
    settle(4);
    chk_bit(run, 1'b0, "no run without override");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      closed_three <= (k == 0);
      closed_four <= (k == 1);
      settle(4);
      chk_bit(run, 1'b1, "override runs");
      chk_bit(maxf, 1'b1, "override max frequency");
      chk_bit(byp, 1'b1, "override bypass");
      chk_bit(rev, k[0], "override direction");
    end
    $display("test override done");
    // Speed selection over all four contact combinations
    @(posedge clk);
    run_cmd <= 1'b1;
    sel_three <= FN_SPEED;
    sel_four <= FN_SPEED;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      closed_three <= k[0];
      closed_four <= k[1];
      settle(4);
      chk_bit(ssel, 1'b1, "speed select");
      chk_val({46'h0, sidx}, {46'h0, k[1:0]}, "speed index");
    end
    $display("test speed done");
    // Every preset value
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      sys_cfg <= k[2:0];
      settle(3);
      chk_bit(spec, k == 2 || k == 3 || k == 5 || k == 6, "special function");
    end
    // Clock enable low freezes the registered outputs
    @(posedge clk);
    ce <= 1'b0;
    sys_cfg <= CFG_SP_A;
    settle(3);
    chk_bit(spec, 1'b0, "frozen while disabled");
    @(posedge clk);
    ce <= 1'b1;
    settle(2);
    chk_bit(spec, 1'b1, "resumes when enabled");
    $display("test preset done");
    // Clock entry: keys ignored outside edit, digit wrap, cursor walk
    press(3'b010);
    settle(2);
    chk_val(value, 48'h0, "key ignored outside edit");
    @(posedge clk);
    edit <= 1'b1;
    press(3'b010);
    settle(2);
    chk_val(value, 48'h1, "digit up");
    press(3'b010);
    settle(2);
    chk_val(value, 48'h0, "digit wraps up");
    press(3'b100);
    settle(2);
    chk_val(value, 48'h1, "digit wraps down");
    for (int k = 0; k < 11; k++) press(3'b001);
    settle(2);
    chk_val({44'h0, cursor}, {44'h0, RTC_LAST}, "cursor at last digit");
    press(3'b001);
    // The pulse stands from the Enter edge to the next one, so look before waiting
    n = 0;
    repeat (3) begin
      #1;
      if (load === 1'b1) n++;
      @(posedge clk);
    end
    #1;
    chk_bit(n == 1, 1'b1, "load pulse for one cycle");
    chk_val({44'h0, cursor}, 48'h0, "cursor wraps");
    $display("test clock entry done");
    summarize();
  end
endmodule
